// File: design/switch_port_link_control_status.sv
/*
 * Link control and link status register word for one switch port, APB slave.
 * Assumes the training machine supplies status levels synchronous to clk,
 * and that the upstream/downstream role is a constant tie-off.
 */
// Contract
// [R01] Power entry field encodes four modes, resets off
// [R02] Receiver may enter L0s even when off
// [R03] Completion boundary bit always reads zero
// [R04] Link disable only at downstream ports
// [R05] Retrain request only at downstream ports
// [R06] Retrain bit always reads back zero
// [R07] Common clock bit stored, resets zero
// [R08] Extended sync selects 4096 FTS, 1024 TS1
// [R09] Bits 10, 11 writable downstream only
// [R10] Speed field reports negotiated speed, resets 0010b
// [R11] Width field reports trained width, resets x1
// [R12] Training error set on fail, cleared at L0
// [R13] Training bit high while training runs
// [R14] Slot clock bit reset from strap input
// [R15] Slot clock default overridable by management load
// [R16] Link active bit mirrors data link active
// [R17] Read-only writes ignored, reserved reads zero
// [R18] Loadable defaults changeable after reset
`timescale 1ns/1ps
module switch_port_link_control_status
    import link_regs_pkg::*;
(
    input wire logic clk,                          // 100 MHz clock
    input wire logic reset_n,                      // Async reset, active low
    input wire logic is_downstream,                // Port role, constant
    input wire logic slot_clock_strap,             // Slot clock strap pin
    input wire default_load_type default_load,     // Management default load
    input wire ltssm_status_type ltssm_status,     // Training machine status
    input wire logic psel,                         // APB select
    input wire logic penable,                      // APB enable
    input wire logic pwrite,                       // APB direction
    input wire logic [11:0] paddr,                 // APB byte address
    input wire logic [31:0] pwdata,                // APB write data
    input wire logic [3:0] pstrb,                  // APB byte strobes
    output logic pready,                           // APB ready
    output logic [31:0] prdata,                    // APB read data
    output logic pslverr,                          // APB error, unmapped
    output link_ctl_type link_ctl                  // Controls to training
);

    ////////////////////////////////////////////////////////////////////////
    // State

    logic [1:0] power_entry;
    logic link_disable;
    logic common_clock;
    logic extended_sync;
    logic autonomous_width;
    logic [1:0] spare_ctl;
    logic [3:0] speed;
    logic [5:0] width;
    logic training_error;
    logic link_training;
    logic link_active;
    logic slot_clock;

    logic [1:0] next_power_entry;
    logic next_link_disable;
    logic next_common_clock;
    logic next_extended_sync;
    logic next_autonomous_width;
    logic [1:0] next_spare_ctl;
    logic [3:0] next_speed;
    logic [5:0] next_width;
    logic next_training_error;
    logic next_link_training;
    logic next_link_active;
    logic next_pready;
    logic [31:0] next_prdata;
    logic next_pslverr;
    link_ctl_type next_link_ctl;

    logic access;
    logic hit;
    logic wr_lo;
    logic wr_hi;
    logic [31:0] read_word;

    ////////////////////////////////////////////////////////////////////////
    // Loadable slot clock default

    // [R14] strap default
    // [R15] management override
    // [R18] after-reset load
    slot_clock_store u_slot_clock (
        .clk(clk),
        .reset_n(reset_n),
        .strap(slot_clock_strap),
        .load_in(default_load),
        .slot_clock(slot_clock)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus decode; access phase takes one wait state, answer registered

    assign access = psel && penable && !pready;
    assign hit = (paddr == link_word_offset);
    assign wr_lo = access && hit && pwrite && pstrb[0];
    assign wr_hi = access && hit && pwrite && pstrb[1];

    // Read image of the whole word
    always_comb begin
        read_word = 32'h0000_0000;
        // [R17] reserved reads zero
        read_word[power_entry_lsb +: 2] = power_entry;
        // [R03] boundary reads zero
        read_word[completion_boundary_bit] = 1'b0;
        read_word[link_disable_bit] = link_disable;
        // [R06] retrain reads zero
        read_word[retrain_bit] = 1'b0;
        read_word[common_clock_bit] = common_clock;
        read_word[extended_sync_bit] = extended_sync;
        read_word[autonomous_width_bit] = autonomous_width;
        read_word[spare_ctl_lo_bit] = spare_ctl[0];
        read_word[spare_ctl_hi_bit] = spare_ctl[1];
        read_word[speed_lsb +: 4] = speed;
        read_word[width_lsb +: 6] = width;
        read_word[training_error_bit] = training_error;
        read_word[link_training_bit] = link_training;
        read_word[slot_clock_bit] = slot_clock;
        read_word[link_active_bit] = link_active;
    end

    ////////////////////////////////////////////////////////////////////////
    // Control fields

    always_comb begin
        next_power_entry = power_entry;
        next_link_disable = link_disable;
        next_common_clock = common_clock;
        next_extended_sync = extended_sync;
        next_autonomous_width = autonomous_width;
        next_spare_ctl = spare_ctl;
        if (wr_lo) begin
            // [R01] power entry write
            next_power_entry = pwdata[power_entry_lsb +: 2];
            // [R04] downstream only disable
            next_link_disable = is_downstream & pwdata[link_disable_bit];
            // [R07] common clock store
            next_common_clock = pwdata[common_clock_bit];
            // [R08] extended sync store
            next_extended_sync = pwdata[extended_sync_bit];
        end
        if (wr_hi) begin
            next_autonomous_width = pwdata[autonomous_width_bit];
            // [R09] downstream writable pair
            next_spare_ctl = is_downstream ? pwdata[spare_ctl_hi_bit:spare_ctl_lo_bit] : 2'h0;
        end
    end

    // Control fields registered; a reset leaves every link feature off
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // [R01] resets to off
            power_entry <= power_entry_off;
            link_disable <= 1'b0;
            common_clock <= 1'b0;
            extended_sync <= 1'b0;
            autonomous_width <= 1'b0;
            spare_ctl <= 2'h0;
        end else begin
            power_entry <= next_power_entry;
            link_disable <= next_link_disable;
            common_clock <= next_common_clock;
            extended_sync <= next_extended_sync;
            autonomous_width <= next_autonomous_width;
            spare_ctl <= next_spare_ctl;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Status fields tracking the training machine

    always_comb begin
        // [R10] negotiated speed
        next_speed = ltssm_status.speed;
        // [R11] negotiated width
        next_width = ltssm_status.width;
        // [R13] training in progress
        next_link_training = ltssm_status.training_active;
        // [R16] data link active
        next_link_active = ltssm_status.dl_active;
        // [R12] fail sets, L0 clears; fail wins on a tie
        next_training_error = training_error;
        if (ltssm_status.training_done) begin
            next_training_error = 1'b0;
        end
        if (ltssm_status.training_failed) begin
            next_training_error = 1'b1;
        end
    end

    // Status registered; the one-cycle lag keeps reads glitch-free
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            // [R10] speed reset
            speed <= speed_reset;
            // [R11] width reset
            width <= width_reset;
            training_error <= 1'b0;
            link_training <= 1'b0;
            link_active <= 1'b0;
        end else begin
            speed <= next_speed;
            width <= next_width;
            training_error <= next_training_error;
            link_training <= next_link_training;
            link_active <= next_link_active;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus answer and control outputs

    always_comb begin
        next_pready = access;
        next_pslverr = access && !hit;
        // [R17] read-only writes ignored
        next_prdata = (access && hit && !pwrite) ? read_word : 32'h0000_0000;
        next_link_ctl.power_entry = next_power_entry;
        // [R02] L0s receive always allowed
        next_link_ctl.rx_l0s_allowed = 1'b1;
        next_link_ctl.link_disable = next_link_disable;
        // [R05] downstream only retrain pulse
        next_link_ctl.retrain_pulse = wr_lo && is_downstream && pwdata[retrain_bit];
        next_link_ctl.common_clock = next_common_clock;
        next_link_ctl.extended_sync = next_extended_sync;
        next_link_ctl.autonomous_width_off = next_autonomous_width;
        // [R08] ordered-set counts
        next_link_ctl.fts_count = next_extended_sync ? fts_count_extended : 13'h0000;
        next_link_ctl.ts1_count = next_extended_sync ? ts1_count_extended : 13'h0000;
    end

    // Bus answer and controls registered; controls reach the training machine together
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            link_ctl <= '0;
        end else begin
            pready <= next_pready;
            prdata <= next_prdata;
            pslverr <= next_pslverr;
            link_ctl <= next_link_ctl;
        end
    end

endmodule : switch_port_link_control_status

// File: design/link_regs_pkg.sv
/*
 * Package for the per-port link control and status register word.
 * Holds offsets, field positions, reset values and the carrier structs
 * shared by the register bank and its small default-store module.
 */
package link_regs_pkg;

    // Register word address (control in low half, status in high half)
    localparam logic [11:0] link_word_offset = 12'h0d0;

    // Control field positions
    localparam int power_entry_lsb = 0;
    localparam int completion_boundary_bit = 3;
    localparam int link_disable_bit = 4;
    localparam int retrain_bit = 5;
    localparam int common_clock_bit = 6;
    localparam int extended_sync_bit = 7;
    localparam int autonomous_width_bit = 9;
    localparam int spare_ctl_lo_bit = 10;
    localparam int spare_ctl_hi_bit = 11;

    // Status field positions
    localparam int speed_lsb = 16;
    localparam int width_lsb = 20;
    localparam int training_error_bit = 26;
    localparam int link_training_bit = 27;
    localparam int slot_clock_bit = 28;
    localparam int link_active_bit = 29;

    // Power-state entry encodings
    localparam logic [1:0] power_entry_off = 2'h0;
    localparam logic [1:0] power_entry_l0s = 2'h1;
    localparam logic [1:0] power_entry_l1 = 2'h2;
    localparam logic [1:0] power_entry_both = 2'h3;

    // Reset values of status fields
    localparam logic [3:0] speed_reset = 4'h2;
    localparam logic [5:0] width_reset = 6'h01;

    // Ordered-set counts for extended synchronisation
    localparam logic [12:0] fts_count_extended = 13'h1000;
    localparam logic [12:0] ts1_count_extended = 13'h0400;

    // Status reported by the training machine
    typedef struct packed {
        logic [3:0] speed;
        logic [5:0] width;
        logic training_failed;
        logic training_done;
        logic training_active;
        logic dl_active;
    } ltssm_status_type;

    // Control outputs towards the training machine
    typedef struct packed {
        logic [1:0] power_entry;
        logic rx_l0s_allowed;
        logic link_disable;
        logic retrain_pulse;
        logic common_clock;
        logic extended_sync;
        logic autonomous_width_off;
        logic [12:0] fts_count;
        logic [12:0] ts1_count;
    } link_ctl_type;

    // Management / configuration-memory load of loadable defaults
    typedef struct packed {
        logic load;
        logic slot_clock;
    } default_load_type;

endpackage : link_regs_pkg

// File: design/slot_clock_store.sv
/*
 * Holds the loadable slot clock default.
 * Assumes the strap is stable around reset release; a later management
 * or configuration-memory load overrides the strapped value.
 */
`timescale 1ns/1ps
module slot_clock_store
    import link_regs_pkg::*;
(
    input wire logic clk,                    // System clock
    input wire logic reset_n,                // Async reset, active low
    input wire logic strap,                  // Slot clock strap level
    input wire default_load_type load_in,    // Override from management path
    output logic slot_clock                  // Current slot clock default
);

    logic captured;
    logic next_captured;
    logic next_slot_clock;

    // Strap caught on the first clock after release; a load wins over it, on that clock too
    always_comb begin
        next_captured = 1'b1;
        next_slot_clock = slot_clock;
        if (!captured) begin
            next_slot_clock = strap;
        end
        if (load_in.load) begin
            next_slot_clock = load_in.slot_clock;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            captured <= 1'b0;
            slot_clock <= 1'b0;
        end else begin
            captured <= next_captured;
            slot_clock <= next_slot_clock;
        end
    end

endmodule : slot_clock_store

// File: bench/link_word_chk.sv
/* Assertions on the link register word, bound to the register bank.
   Sees only the bank's ports; one clock domain. */
`timescale 1ns/1ps
module link_word_chk
    import link_regs_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic reset_n, // Async reset, active low
    input wire logic is_downstream, // Port role
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB strobes
    input wire logic pready, // APB ready
    input wire logic [31:0] prdata, // APB read data
    input wire logic pslverr, // APB error
    input wire link_ctl_type link_ctl // Controls to training
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    ////////////////////
    // Access taken, and a write of the low byte
    sequence s_take; psel && penable && !pready; endsequence
    sequence s_wr; s_take ##0 pwrite && paddr == link_word_offset && pstrb[0]; endsequence
    property p_pw; s_wr |=> link_ctl.power_entry == $past(pwdata[1:0]); endproperty
    a_pw: assert property (p_pw) else $error("power entry not stored");
    property p_rx; $past(reset_n) |-> link_ctl.rx_l0s_allowed; endproperty
    a_rx: assert property (p_rx) else $error("receiver idle entry blocked");
    property p_ro; pready |-> !prdata[3] && !prdata[5]; endproperty
    a_ro: assert property (p_ro) else $error("fixed zero bit read as one");
    property p_up; !is_downstream |-> !link_ctl.link_disable && !link_ctl.retrain_pulse; endproperty
    a_up: assert property (p_up) else $error("upstream link control active");
    property p_rt; s_wr ##0 is_downstream && pwdata[5] |-> ##[1:2] link_ctl.retrain_pulse; endproperty
    a_rt: assert property (p_rt) else $error("retrain not requested");
    property p_one; link_ctl.retrain_pulse |=> !link_ctl.retrain_pulse; endproperty
    a_one: assert property (p_one) else $error("retrain request stuck");
    property p_ext; $stable(link_ctl.extended_sync) |-> link_ctl.fts_count == (link_ctl.extended_sync ?
        fts_count_extended : 13'h0) && link_ctl.ts1_count == (link_ctl.extended_sync ? ts1_count_extended : 13'h0);
    endproperty
    a_ext: assert property (p_ext) else $error("ordered set count wrong");
    property p_sp; pready && !is_downstream |-> prdata[11:10] == 2'h0 && !prdata[4]; endproperty
    a_sp: assert property (p_sp) else $error("upstream spare bit set");
    property p_err; pready |-> pslverr == (paddr != link_word_offset) && (!pslverr || prdata == 32'h0); endproperty
    a_err: assert property (p_err) else $error("error response wrong");
    property p_rs; pready |-> !prdata[2] && !prdata[8] && prdata[15:12] == 4'h0 && prdata[31:30] == 2'h0; endproperty
    a_rs: assert property (p_rs) else $error("reserved bit read as one");
endmodule : link_word_chk
bind switch_port_link_control_status link_word_chk u_chk (.clk, .reset_n, .is_downstream, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .link_ctl);

// File: bench/link_partner_model.sv
/* Training machine stand-in: answers a retrain request with a 12-cycle run.
   Assumes the bench sets fail_train before the retrain it should spoil. */
`timescale 1ns/1ps
module link_partner_model
    import link_regs_pkg::*;
(
    input wire logic clk, // Clock
    input wire logic reset_n, // Async reset, active low
    input wire link_ctl_type link_ctl, // Controls from the port
    input wire logic fail_train, // Spoil the next run
    output ltssm_status_type status // Status to the port
);
    logic [3:0] cnt;
    ////////////////////
    // training run; speed and width fixed
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt <= 4'h0;
            status <= '{speed: 4'h2, width: 6'h01, default: 1'b0};
        end else begin
            status.training_failed <= 1'b0;
            status.training_done <= 1'b0;
            if (link_ctl.retrain_pulse) begin
                cnt <= 4'hc;
                status.training_active <= 1'b1;
                status.dl_active <= 1'b0;
            end else if (cnt == 4'h1) begin
                cnt <= 4'h0;
                status.training_active <= 1'b0;
                status.training_failed <= fail_train;
                status.training_done <= !fail_train;
                status.dl_active <= !fail_train;
            end else if (cnt != 4'h0) begin
                cnt <= cnt - 4'h1;
            end
            if (link_ctl.link_disable) begin
                status.dl_active <= 1'b0;
            end
        end
    end
endmodule : link_partner_model

// File: bench/switch_port_link_control_status_tb.sv
/* Bench for the link register word: APB tasks and a training stand-in.
   Assumes the package, checker and partner are compiled first. */
`timescale 1ns/1ps
module switch_port_link_control_status_tb
    import link_regs_pkg::*;
;
    logic clk = 0, reset_n = 0, is_downstream = 0, strap = 1, fail_train = 0, rerr;
    logic psel = 0, penable = 0, pwrite = 0, pready, pslverr;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic [3:0] pstrb = 4'h0;
    default_load_type default_load = '0;
    ltssm_status_type ltssm_status;
    link_ctl_type link_ctl;
    int error_cnt = 0, n_compared = 0;
    localparam logic [11:0] a = link_word_offset;
    always #5 clk = ~clk;
    switch_port_link_control_status dut (.clk, .reset_n, .is_downstream, .slot_clock_strap(strap), .default_load,
        .ltssm_status, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr, .link_ctl);
    link_partner_model partner (.clk, .reset_n, .link_ctl, .fail_train, .status(ltssm_status));
    ////////////////////
    task automatic finish_test;
        $display("compared %0d, errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One APB transfer; ready and answer are taken at the rising edge, before flops update
    task automatic apb(input logic w, input logic [11:0] ad, input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
            if (n > 20) begin
                error_cnt++;
                finish_test();
            end
        end while (pready !== 1'b1);
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [31:0] d);
        apb(1'b1, a, d, 4'hf);
    endtask : wr
    task automatic rd(input logic [11:0] ad, input logic [31:0] exp);
        apb(1'b0, ad, 32'h0, 4'h0);
        chk(rdata, exp);
    endtask : rd
    task automatic rst(input logic ds, input logic sc);
        reset_n <= 1'b0;
        is_downstream <= ds;
        strap <= sc;
        repeat (3) @(posedge clk);
        reset_n <= 1'b1;
        repeat (2) @(posedge clk);
    endtask : rst
    ////////////////////
    initial begin
        rst(1'b0, 1'b1);
        rd(a, 32'h1012_0000);
        chk(link_ctl.rx_l0s_allowed, 1'b1);
        wr(32'hffff_ffff);
        rd(a, 32'h1012_02c3);
        chk(link_ctl.fts_count, 32'h1000);
        chk(link_ctl.ts1_count, 32'h0400);
        chk(link_ctl.common_clock, 1'b1);
        chk({link_ctl.extended_sync, link_ctl.autonomous_width_off}, 32'h3);
        for (int i = 0; i < 4; i++) begin
            wr(i);
            chk(link_ctl.power_entry, i);
        end
        chk(link_ctl.fts_count, 32'h0);
        apb(1'b1, a, 32'h0000_0040, 4'h2);
        rd(a, 32'h1012_0003);
        apb(1'b1, 12'h0d4, 32'hffff_ffff, 4'hf);
        chk(rerr, 1'b1);
        rd(12'h0d4, 32'h0);
        rd(a, 32'h1012_0003);
        $display("upstream test done");
        rst(1'b1, 1'b0);
        rd(a, 32'h0012_0000);
        wr(32'hffff_ffff);
        rd(a, 32'h0812_0ed3);
        chk(link_ctl.link_disable, 1'b1);
        wr(32'h20);
        rd(a, 32'h0812_0000);
        repeat (20) @(posedge clk);
        rd(a, 32'h2012_0000);
        fail_train <= 1'b1;
        wr(32'h20);
        repeat (20) @(posedge clk);
        rd(a, 32'h0412_0000);
        fail_train <= 1'b0;
        wr(32'h20);
        repeat (20) @(posedge clk);
        rd(a, 32'h2012_0000);
        wr(32'h10);
        rd(a, 32'h0012_0010);
        default_load <= '{load: 1'b1, slot_clock: 1'b1};
        @(posedge clk);
        default_load <= '0;
        rd(a, 32'h1012_0010);
        $display("downstream test done");
        finish_test();
    end
endmodule : switch_port_link_control_status_tb
